// ---- hw/etca_edge_sync.sv ----
/*
  Two-flop synchroniser with a rising-edge pulse on the settled level.
  Assumes the input is slower than half the core clock.
*/
`default_nettype none
module etca_edge_sync
  import etca_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output var  logic rise_pulse
);

  etca_sync_st_t st_reg;
  etca_sync_st_t st_next;

  // ****************************************
  // Synchroniser and edge detect
  // ****************************************
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = async_in;
    st_next.stable = st_reg.meta;
    st_next.prev   = st_reg.stable;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= ETCA_SYNC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_pulse = st_reg.stable & ~st_reg.prev;

  // ****************************************
  // Checks
  // ****************************************
  a_rise_latency: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(async_in) |-> ##2 rise_pulse)
    else $error("Input edge did not give a pulse two cycles later");

  a_rise_single: assert property (
    @(posedge core_clk) disable iff (rst)
    rise_pulse |=> !rise_pulse)
    else $error("Edge pulse lasted more than one cycle");

endmodule
`default_nettype wire

// ---- hw/etca_prescaler.sv ----
/*
  Programmable prescaler counting slow clock edges.
  Assumes slow_rise is a one-cycle pulse per slow clock period.
*/
`default_nettype none
module etca_prescaler
  import etca_pkg::*;
#(
  parameter int PRE_W = ETCA_PRE_W
)(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             reload,
  input  wire logic [PRE_W-1:0] divisor,
  input  wire logic             slow_rise,
  output var  logic             wrap_pulse
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } etca_pre_st_t;

  etca_pre_st_t     st_reg;
  etca_pre_st_t     st_next;
  logic [PRE_W-1:0] term;

  // ****************************************
  // Divider
  // ****************************************
  assign term       = divisor - PRE_W'(1);
  assign wrap_pulse = run & ~reload & slow_rise & (st_reg.cnt == term);

  always_comb begin
    st_next = st_reg;
    if (reload) begin
      st_next.cnt = '0;
    end else if (run & slow_rise) begin
      if (wrap_pulse) begin
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_wrap_at_term: assert property (
    @(posedge core_clk) disable iff (rst)
    wrap_pulse |-> st_reg.cnt == divisor - PRE_W'(1) ##1 st_reg.cnt == '0)
    else $error("Prescaler wrapped at the wrong count");

  a_reload_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    reload |=> st_reg.cnt == '0)
    else $error("Prescaler not reloaded");

  a_idle_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !run && !reload |=> $stable(st_reg.cnt))
    else $error("Prescaler moved while stopped");

endmodule
`default_nettype wire

// ---- hw/etca_timer.sv ----
/*
  Elapsed time counter with alarm compare and sticky event flags,
  behind an Avalon-MM slave with one wait state.
  Assumes slow_clock_source and second_tick are levels slower than
  half of core_clk.
*/
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none
module etca_timer
  import etca_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire etca_bus_req_t bus_req,
  output var  etca_bus_rsp_t bus_rsp,
  input  wire logic          slow_clock_source,
  input  wire logic          second_tick,
  output var  logic          irq
);

  etca_core_st_t st_reg;
  etca_core_st_t st_next;
  logic          slow_rise;
  logic          sec_rise;
  logic          wrap_pulse;
  logic          acc_done;
  logic          mode_wr;
  logic          alarm_wr;
  logic          flags_rd;
  logic          restart;
  logic          inc;
  logic          alarm_set;

  // ****************************************
  // Tick inputs and prescaler
  // ****************************************
  etca_edge_sync u_slow_sync (
    .core_clk   (core_clk),
    .rst        (rst),
    .async_in   (slow_clock_source),
    .rise_pulse (slow_rise)
  );

  etca_edge_sync u_sec_sync (
    .core_clk   (core_clk),
    .rst        (rst),
    .async_in   (second_tick),
    .rise_pulse (sec_rise)
  );

  etca_prescaler #(
    .PRE_W (ETCA_PRE_W)
  ) u_pre (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (~st_reg.timer_disable),
    .reload     (restart),
    .divisor    (st_reg.prescale_divisor),
    .slow_rise  (slow_rise),
    .wrap_pulse (wrap_pulse)
  );

  // ****************************************
  // Access decode
  // ****************************************
  assign acc_done = (bus_req.read | bus_req.write) & st_reg.ack;
  assign mode_wr  = acc_done & bus_req.write & (bus_req.address == ETCA_OFF_MODE);
  assign alarm_wr = acc_done & bus_req.write & (bus_req.address == ETCA_OFF_ALARM);
  assign flags_rd = acc_done & bus_req.read & (bus_req.address == ETCA_OFF_FLAGS);
  assign restart  = mode_wr & bus_req.byteenable[2]
                  & bus_req.writedata[ETCA_RESTART_BIT];

  // ****************************************
  // Count events
  // ****************************************
  assign inc = ~st_reg.timer_disable & ~restart
             & (st_reg.second_tick_select ? sec_rise : wrap_pulse);
  assign alarm_set = inc & (st_reg.current_count == st_reg.alarm_value);

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] rd_word;
    logic [31:0] mode_img;
    logic [31:0] mode_new;
    logic [1:0]  clr;
    rd_word  = 32'h0;
    mode_img = 32'h0;
    mode_img[ETCA_DIV_LSB +: ETCA_PRE_W] = st_reg.prescale_divisor;
    mode_img[ETCA_ALM_EN_BIT]  = st_reg.alarm_irq_enable;
    mode_img[ETCA_WRAP_EN_BIT] = st_reg.wrap_irq_enable;
    mode_new = 32'h0;
    clr      = flags_rd ? st_reg.clr_mask : 2'h0;
    st_next  = st_reg;
    st_next.ack = (bus_req.read | bus_req.write) & ~st_reg.ack;
    case (bus_req.address)
      ETCA_OFF_MODE: begin
        rd_word = mode_img;
      end
      ETCA_OFF_ALARM: begin
        rd_word = st_reg.alarm_value;
      end
      ETCA_OFF_VALUE: begin
        rd_word = st_reg.current_count;
      end
      ETCA_OFF_FLAGS: begin
        rd_word[ETCA_ALARM_BIT] = st_reg.alarm_flag;
        rd_word[ETCA_WRAP_BIT]  = st_reg.prescale_wrap_flag;
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
    if (bus_req.read & ~st_reg.ack) begin
      st_next.rdata    = rd_word;
      st_next.clr_mask = 2'h0;
      if (bus_req.address == ETCA_OFF_FLAGS) begin
        st_next.clr_mask = rd_word[1:0];
      end
    end
    if (alarm_wr) begin
      st_next.alarm_value = be_merge(st_reg.alarm_value, bus_req.writedata,
                                     bus_req.byteenable);
    end
    if (mode_wr) begin
      mode_img[ETCA_DISABLE_BIT] = st_reg.timer_disable;
      mode_img[ETCA_SEC_SEL_BIT] = st_reg.second_tick_select;
      mode_new = be_merge(mode_img, bus_req.writedata, bus_req.byteenable);
      st_next.prescale_divisor   = mode_new[ETCA_DIV_LSB +: ETCA_PRE_W];
      st_next.alarm_irq_enable   = mode_new[ETCA_ALM_EN_BIT];
      st_next.wrap_irq_enable    = mode_new[ETCA_WRAP_EN_BIT];
      st_next.timer_disable      = mode_new[ETCA_DISABLE_BIT];
      st_next.second_tick_select = mode_new[ETCA_SEC_SEL_BIT];
    end
    if (restart) begin
      st_next.current_count = ETCA_COUNT_RST;
    end else if (inc) begin
      st_next.current_count = st_reg.current_count + 32'h1;
    end
    st_next.alarm_flag = (st_reg.alarm_flag & ~clr[ETCA_ALARM_BIT])
                       | alarm_set;
    st_next.prescale_wrap_flag = (st_reg.prescale_wrap_flag & ~clr[ETCA_WRAP_BIT])
                               | wrap_pulse;
    st_next.irq = (st_next.alarm_flag & st_next.alarm_irq_enable)
                | (st_next.prescale_wrap_flag & st_next.wrap_irq_enable);
  end

  // ****************************************
  // State register and outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= ETCA_CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rsp = '{
    readdata:    st_reg.rdata,
    waitrequest: (bus_req.read | bus_req.write) & ~st_reg.ack
  };
  assign irq     = st_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_req(logic [31:0] off);
    bus_req.read && !st_reg.ack && bus_req.address == off;
  endsequence

  sequence s_rd_done;
    bus_req.read && st_reg.ack;
  endsequence

  a_restart_zero: assert property (
    restart |=> st_reg.current_count == 32'h0)
    else $error("Restart did not clear the counter");

  a_disable_hold: assert property (
    st_reg.timer_disable && !restart |=> $stable(st_reg.current_count))
    else $error("Counter moved while disabled");

  a_mode_wo_bits: assert property (
    s_rd_req(ETCA_OFF_MODE) ##1 s_rd_done |-> bus_rsp.readdata[ETCA_DISABLE_BIT] == 1'b0
      && bus_rsp.readdata[ETCA_SEC_SEL_BIT] == 1'b0
      && bus_rsp.readdata[ETCA_RESTART_BIT] == 1'b0)
    else $error("Write-only mode bit read back");

  a_sec_step: assert property (
    st_reg.second_tick_select && !st_reg.timer_disable && !restart
    |=> st_reg.current_count == $past(st_reg.current_count) + {31'h0, $past(sec_rise)})
    else $error("Counter not stepped by second tick");

  a_pre_step: assert property (
    !st_reg.second_tick_select && !st_reg.timer_disable && !restart
    |=> st_reg.current_count == $past(st_reg.current_count) + {31'h0, $past(wrap_pulse)})
    else $error("Counter not stepped by prescaler wrap");

  a_alarm_match: assert property (
    $rose(st_reg.alarm_flag)
    |-> $past(inc) && $past(st_reg.current_count) == $past(st_reg.alarm_value))
    else $error("Alarm flag rose without a match");

  a_alarm_plus_one: assert property (
    $rose(st_reg.alarm_flag) |-> st_reg.current_count == $past(st_reg.alarm_value) + 32'h1)
    else $error("Alarm flag rose at the wrong count");

  a_value_read: assert property (
    s_rd_req(ETCA_OFF_VALUE) ##1 s_rd_done |-> bus_rsp.readdata == $past(st_reg.current_count))
    else $error("Value read did not return the counter");

  a_flags_clear: assert property (
    (s_rd_req(ETCA_OFF_FLAGS) and (!alarm_set && !wrap_pulse))
    ##1 (s_rd_done and (!alarm_set && !wrap_pulse))
    |=> !st_reg.alarm_flag && !st_reg.prescale_wrap_flag)
    else $error("Status read did not clear the flags");

  a_flags_upper: assert property (
    s_rd_req(ETCA_OFF_FLAGS) ##1 s_rd_done |-> bus_rsp.readdata[31:2] == 30'h0)
    else $error("Unused status bits not zero");

  a_irq_level: assert property (
    irq == ((st_reg.alarm_flag && st_reg.alarm_irq_enable)
      || (st_reg.prescale_wrap_flag && st_reg.wrap_irq_enable)))
    else $error("Interrupt does not follow enabled flags");

  a_count_wrap: assert property (
    inc && st_reg.current_count == 32'hffff_ffff |=> st_reg.current_count == 32'h0)
    else $error("Counter did not wrap to zero");

  a_set_wins: assert property (
    (alarm_set |=> st_reg.alarm_flag) and (wrap_pulse |=> st_reg.prescale_wrap_flag))
    else $error("Event lost against a status clear");

endmodule
`default_nettype wire

// ---- pkg/etca_pkg.sv ----
/*
  Shared constants and types of the elapsed time counter with alarm:
  register byte addresses, field positions, reset values, bus carriers
  and state records.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
`default_nettype none
package etca_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ETCA_DATA_W = 32;
  localparam int ETCA_PRE_W  = 16;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] ETCA_OFF_MODE  = 32'h400e_1430;
  localparam logic [31:0] ETCA_OFF_ALARM = 32'h400e_1434;
  localparam logic [31:0] ETCA_OFF_VALUE = 32'h400e_1438;
  localparam logic [31:0] ETCA_OFF_FLAGS = 32'h400e_143c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ETCA_DIV_LSB     = 0;
  localparam int ETCA_ALM_EN_BIT  = 16;
  localparam int ETCA_WRAP_EN_BIT = 17;
  localparam int ETCA_RESTART_BIT = 18;
  localparam int ETCA_DISABLE_BIT = 20;
  localparam int ETCA_SEC_SEL_BIT = 24;
  localparam int ETCA_ALARM_BIT   = 0;
  localparam int ETCA_WRAP_BIT    = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] ETCA_DIV_RST   = 16'h8000;
  localparam logic [31:0] ETCA_ALARM_RST = 32'hffff_ffff;
  localparam logic [31:0] ETCA_COUNT_RST = 32'h0000_0000;

  // ****************************************
  // Carriers and state records
  // ****************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } etca_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } etca_bus_rsp_t;

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } etca_sync_st_t;

  typedef struct packed {
    logic [31:0] alarm_value;
    logic [31:0] current_count;
    logic [31:0] rdata;
    logic [15:0] prescale_divisor;
    logic [1:0]  clr_mask;
    logic        alarm_irq_enable;
    logic        wrap_irq_enable;
    logic        timer_disable;
    logic        second_tick_select;
    logic        alarm_flag;
    logic        prescale_wrap_flag;
    logic        ack;
    logic        irq;
  } etca_core_st_t;

  localparam etca_sync_st_t ETCA_SYNC_RST = '{default: 1'b0};
  localparam etca_core_st_t ETCA_CORE_RST = '{
    alarm_value:      ETCA_ALARM_RST,
    current_count:    ETCA_COUNT_RST,
    prescale_divisor: ETCA_DIV_RST,
    default:          '0
  };

endpackage
`default_nettype wire

// ---- testbench/etca_timer_tb_top.sv ----
/*
  Self-checking bench of the elapsed time counter with alarm.
  Assumes the one-wait-state Avalon-MM slave of etca_timer and inputs
  driven at core_clk rising edges.
*/
`default_nettype none
module etca_timer_tb_top
  import etca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic          core_clk;
  logic          rst;
  etca_bus_req_t bus_req;
  etca_bus_rsp_t bus_rsp;
  logic          slow_clock_source;
  logic          second_tick;
  logic          irq;
  int            err_total;
  int            n_tests;

  etca_timer DUT (
    .core_clk          (core_clk),
    .rst               (rst),
    .bus_req           (bus_req),
    .bus_rsp           (bus_rsp),
    .slow_clock_source (slow_clock_source),
    .second_tick       (second_tick),
    .irq               (irq)
  );

  initial begin
    core_clk = 1'b0;
    err_total = 0;
    n_tests = 0;
  end

  always #4 core_clk = ~core_clk;

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic exp);
    @(posedge core_clk);
    n_tests++;
    if (irq !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, irq, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic bus_acc(input logic is_wr, input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    bus_req.read       <= ~is_wr;
    bus_req.write      <= is_wr;
    bus_req.address    <= a;
    bus_req.writedata  <= d;
    bus_req.byteenable <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 100);
    if (bus_rsp.waitrequest !== 1'b0) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, 1'b1, 1'b0);
    end
    q = bus_rsp.readdata;
    bus_req.read  <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_acc(1'b0, a, 32'h0000_0000, q);
    check32(q, exp);
  endtask

  task automatic val_chk(input logic [31:0] exp);
    logic [31:0] q0;
    logic [31:0] q1;
    int          n;
    n = 0;
    bus_acc(1'b0, ETCA_OFF_VALUE, 32'h0000_0000, q1);
    do begin
      q0 = q1;
      bus_acc(1'b0, ETCA_OFF_VALUE, 32'h0000_0000, q1);
      n++;
    end while (q0 !== q1 && n < 5);
    check32(q1, exp);
  endtask

  // Rising edges on the slow clock (sel 0) or the second tick (sel 1)
  task automatic pulse(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      if (sel) second_tick <= 1'b1;
      else slow_clock_source <= 1'b1;
      repeat (2) @(posedge core_clk);
      if (sel) second_tick <= 1'b0;
      else slow_clock_source <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst               = 1'b1;
    bus_req           = '0;
    slow_clock_source = 1'b0;
    second_tick       = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd_chk(ETCA_OFF_MODE, 32'h0000_8000);
    rd_chk(ETCA_OFF_ALARM, 32'hffff_ffff);
    val_chk(32'h0000_0000);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0000);
    rd_chk(32'h400e_1440, 32'h0000_0000);
    check1(1'b0);
    $display("test reset done");
    wr(ETCA_OFF_MODE, 32'h0004_0003);
    pulse(1'b0, 3);
    val_chk(32'h0000_0001);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0000);
    pulse(1'b0, 2);
    val_chk(32'h0000_0001);
    pulse(1'b0, 1);
    val_chk(32'h0000_0002);
    wr(ETCA_OFF_VALUE, 32'h0000_00aa);
    val_chk(32'h0000_0002);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    $display("test prescaler done");
    wr(ETCA_OFF_MODE, 32'h0004_0003);
    val_chk(32'h0000_0000);
    wr(ETCA_OFF_ALARM, 32'h0000_0002);
    wr(ETCA_OFF_MODE, 32'h0001_0003);
    rd_chk(ETCA_OFF_ALARM, 32'h0000_0002);
    pulse(1'b0, 6);
    val_chk(32'h0000_0002);
    check1(1'b0);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    pulse(1'b0, 3);
    check1(1'b1);
    val_chk(32'h0000_0003);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0003);
    check1(1'b0);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0000);
    wr(ETCA_OFF_MODE, 32'h0002_0003);
    pulse(1'b0, 3);
    check1(1'b1);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    check1(1'b0);
    $display("test alarm done");
    wr(ETCA_OFF_MODE, 32'h0010_0003);
    rd_chk(ETCA_OFF_MODE, 32'h0000_0003);
    pulse(1'b0, 6);
    val_chk(32'h0000_0004);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0000);
    wr(ETCA_OFF_MODE, 32'h0000_0003);
    pulse(1'b0, 3);
    val_chk(32'h0000_0005);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    $display("test disable done");
    wr(ETCA_OFF_MODE, 32'h0104_0003);
    val_chk(32'h0000_0000);
    rd_chk(ETCA_OFF_MODE, 32'h0000_0003);
    pulse(1'b1, 2);
    val_chk(32'h0000_0002);
    pulse(1'b0, 3);
    val_chk(32'h0000_0002);
    rd_chk(ETCA_OFF_FLAGS, 32'h0000_0002);
    $display("test tick select done");
    give_verdict();
  end

endmodule
`default_nettype wire
